//--- inc/cct_pkg.sv
// constants for the 16-bit capture/compare timer: register map, field layout, codes
// assumes a 32-bit apb slave with byte addresses and one register per aligned word
package cct_pkg;
    // =====================================================================
    // register map
    localparam logic [7:0] OFF_MODE    = 8'h00;
    localparam logic [7:0] OFF_CTRL    = 8'h04;
    localparam logic [7:0] OFF_IRQ_EN  = 8'h08;
    localparam logic [7:0] OFF_STATUS  = 8'h0c;
    localparam logic [7:0] OFF_IO_CTRL = 8'h10;
    localparam logic [7:0] OFF_COUNT   = 8'h14;
    localparam logic [7:0] OFF_GR_A    = 8'h18;
    localparam logic [7:0] OFF_GR_STEP = 8'h04;
    // =====================================================================
    // field positions
    localparam int unsigned MODE_RUN_BIT   = 7;
    localparam int unsigned MODE_BUF_B_BIT = 5;
    localparam int unsigned MODE_BUF_A_BIT = 4;
    localparam int unsigned MODE_PWM_LSB   = 0;
    localparam logic [31:0] MODE_ONES      = 32'h0000_0048;
    localparam int unsigned CTRL_CLR_BIT   = 7;
    localparam int unsigned CTRL_CKS_LSB   = 4;
    localparam int unsigned CTRL_LVL_LSB   = 0;
    localparam int unsigned ST_OVF_BIT     = 4;
    localparam int unsigned IO_FIELD_W     = 4;
    localparam int unsigned IO_CAP_BIT     = 2;
    localparam int unsigned EDGE_BOTH_BIT  = 1;
    localparam int unsigned CKS_EXT_BIT    = 2;
    // =====================================================================
    // codes
    localparam logic [1:0] CKS_DIV1   = 2'h0;
    localparam logic [1:0] CKS_DIV2   = 2'h1;
    localparam logic [1:0] CKS_DIV4   = 2'h2;
    localparam logic [1:0] CKS_DIV8   = 2'h3;
    localparam logic [1:0] ACT_NONE   = 2'h0;
    localparam logic [1:0] ACT_ZERO   = 2'h1;
    localparam logic [1:0] ACT_ONE    = 2'h2;
    localparam logic [1:0] ACT_TOGGLE = 2'h3;
    // =====================================================================
    // reset values
    localparam logic [2:0]  RST_CKS  = 3'h0;
    localparam logic [2:0]  RST_PWM  = 3'h0;
    localparam logic [4:0]  RST_FLAG = 5'h00;
    localparam logic [15:0] RST_IO   = 16'h0000;
    localparam logic [2:0]  RST_DIV  = 3'h0;
endpackage

//--- core/cct_sync.sv
// two-flop synchroniser for a group of asynchronous pin levels
// assumes each bit is an independent level; no bus coherence
`timescale 1ns/1ps
module cct_sync #(
    parameter int unsigned WIDTH = 5
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            s1_q <= '0;
            s2_q <= '0;
        end else begin
            s1_q <= i_async;
            s2_q <= s1_q;
        end
    end

    assign o_sync = s2_q;
endmodule // cct_sync

//--- core/cct_chan.sv
// one channel: edge detection for capture and the pin output level
// assumes i_pin_sync is already synchronised to i_clk
`timescale 1ns/1ps
module cct_chan import cct_pkg::*; (
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic       i_pin_sync,
    input  wire logic       i_cap_mode,
    input  wire logic [1:0] i_cfg,
    input  wire logic       i_match_own,
    input  wire logic       i_match_period,
    input  wire logic       i_pwm_en,
    input  wire logic       i_preset,
    input  wire logic       i_preset_val,
    output logic            o_capture,
    output logic            o_pin_out
);
    logic prev_q;
    logic pin_q;
    logic edge_hit;

    always_ff @(posedge i_clk) begin
        if (i_rst) prev_q <= 1'b0;
        else       prev_q <= i_pin_sync;
    end

    // =====================================================================
    // capture edge select
    always_comb begin
        if (i_cfg[EDGE_BOTH_BIT]) edge_hit = i_pin_sync ^ prev_q;
        else if (i_cfg[0])        edge_hit = prev_q & ~i_pin_sync;
        else                      edge_hit = i_pin_sync & ~prev_q;
    end
    assign o_capture = i_cap_mode & edge_hit;

    // =====================================================================
    // output level
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            pin_q <= 1'b0;
        end else if (i_preset) begin
            pin_q <= i_preset_val;
        end else if (i_cap_mode) begin
            pin_q <= pin_q;
        end else if (i_pwm_en) begin
            if (i_match_own)         pin_q <= 1'b1;
            else if (i_match_period) pin_q <= 1'b0;
        end else if (i_match_own) begin
            unique case (i_cfg)
                ACT_NONE:   pin_q <= pin_q;
                ACT_ZERO:   pin_q <= 1'b0;
                ACT_ONE:    pin_q <= 1'b1;
                ACT_TOGGLE: pin_q <= ~pin_q;
            endcase
        end
    end
    assign o_pin_out = pin_q;
endmodule // cct_chan

//--- core/cct_timer.sv
// top of the 16-bit capture/compare timer with apb register access
// assumes apb master on I_REF_CLK; channel pins and event input are asynchronous
`timescale 1ns/1ps
module cct_timer import cct_pkg::*; #(
    parameter int unsigned CNT_W = 16
) (
    input  wire logic        I_REF_CLK,
    input  wire logic        I_SYS_RST,
    input  wire logic        I_PSEL,
    input  wire logic        I_PENABLE,
    input  wire logic        I_PWRITE,
    input  wire logic [7:0]  I_PADDR,
    input  wire logic [31:0] I_PWDATA,
    output logic      [31:0] O_PRDATA,
    output logic             O_PREADY,
    output logic             O_PSLVERR,
    input  wire logic        I_EXT_EVENT_IN,
    input  wire logic        I_CHAN_A_PIN,
    input  wire logic        I_CHAN_B_PIN,
    input  wire logic        I_CHAN_C_PIN,
    input  wire logic        I_CHAN_D_PIN,
    output logic             O_CHAN_A_PIN,
    output logic             O_CHAN_B_PIN,
    output logic             O_CHAN_C_PIN,
    output logic             O_CHAN_D_PIN,
    output logic             O_CHAN_A_PIN_OE_N,
    output logic             O_CHAN_B_PIN_OE_N,
    output logic             O_CHAN_C_PIN_OE_N,
    output logic             O_CHAN_D_PIN_OE_N,
    output logic             O_IRQ
);
    // =====================================================================
    // state
    logic [CNT_W-1:0] main_count_q;
    logic [CNT_W-1:0] gr_q [4];
    logic             run_q;
    logic             buffer_pair_a_en_q;
    logic             buffer_pair_b_en_q;
    logic [2:0]       pwm_q;
    logic             clear_on_match_a_q;
    logic [2:0]       cks_q;
    logic [4:0]       irq_en_q;
    logic [4:0]       status_q;
    logic [15:0]      io_q;
    logic [2:0]       div_q;
    logic             ext_prev_q;
    logic             irq_q;
    logic             pready_q;
    logic             pslverr_q;
    logic [31:0]      prdata_q;
    logic [31:0]      rdata_d;
    logic             err_d;
    logic [4:0]       pins_s;
    logic [3:0]       cap;
    logic [3:0]       cap_ev;
    logic [3:0]       cmp_match;
    logic [3:0]       pin_out;
    logic [3:0]       buf_blk;
    logic [1:0]       buf_en;
    logic [3:0]       pwm_en;
    logic             tick;
    logic             count_en;
    logic             clr_hit;
    logic             ovf;
    logic             wr_en;
    logic             wr_ctrl;
    logic             wr_count;
    logic             wr_status;

    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (I_SYS_RST);

    function automatic logic hit(input logic [7:0] off);
        return wr_en && (I_PADDR == off);
    endfunction

    function automatic logic [7:0] gr_off(input int unsigned idx);
        return OFF_GR_A + 8'(idx * OFF_GR_STEP);
    endfunction

    assign wr_en     = I_PSEL & I_PENABLE & I_PWRITE & pready_q;
    assign wr_ctrl   = hit(OFF_CTRL);
    assign wr_count  = hit(OFF_COUNT);
    assign wr_status = hit(OFF_STATUS);

    // =====================================================================
    // input synchronisers
    cct_sync #(
        .WIDTH (5)
    ) u_sync (
        .i_clk   (I_REF_CLK),
        .i_rst   (I_SYS_RST),
        .i_async ({I_EXT_EVENT_IN, I_CHAN_D_PIN, I_CHAN_C_PIN, I_CHAN_B_PIN, I_CHAN_A_PIN}),
        .o_sync  (pins_s)
    );

    // =====================================================================
    // configuration registers
    always_ff @(posedge I_REF_CLK) begin
        if (I_SYS_RST) begin
            run_q              <= 1'b0;
            buffer_pair_a_en_q <= 1'b0;
            buffer_pair_b_en_q <= 1'b0;
            pwm_q              <= RST_PWM;
        end else if (hit(OFF_MODE)) begin
            run_q              <= I_PWDATA[MODE_RUN_BIT];
            buffer_pair_a_en_q <= I_PWDATA[MODE_BUF_A_BIT];
            buffer_pair_b_en_q <= I_PWDATA[MODE_BUF_B_BIT];
            pwm_q              <= I_PWDATA[MODE_PWM_LSB +: 3];
        end
    end

    always_ff @(posedge I_REF_CLK) begin
        if (I_SYS_RST) begin
            clear_on_match_a_q <= 1'b0;
            cks_q              <= RST_CKS;
        end else if (wr_ctrl) begin
            clear_on_match_a_q <= I_PWDATA[CTRL_CLR_BIT];
            cks_q              <= I_PWDATA[CTRL_CKS_LSB +: 3];
        end
    end

    always_ff @(posedge I_REF_CLK) begin
        if (I_SYS_RST)                io_q <= RST_IO;
        else if (hit(OFF_IO_CTRL))    io_q <= I_PWDATA[15:0];
    end

    always_ff @(posedge I_REF_CLK) begin
        if (I_SYS_RST)                irq_en_q <= RST_FLAG;
        else if (hit(OFF_IRQ_EN))     irq_en_q <= I_PWDATA[4:0];
    end

    // =====================================================================
    // count source
    always_ff @(posedge I_REF_CLK) begin
        if (I_SYS_RST) begin
            div_q      <= RST_DIV;
            ext_prev_q <= 1'b0;
        end else begin
            div_q      <= div_q + 3'h1;
            ext_prev_q <= pins_s[4];
        end
    end

    always_comb begin
        if (cks_q[CKS_EXT_BIT]) begin
            tick = pins_s[4] & ~ext_prev_q;
        end else begin
            unique case (cks_q[1:0])
                CKS_DIV1: tick = 1'b1;
                CKS_DIV2: tick = div_q[0];
                CKS_DIV4: tick = &div_q[1:0];
                CKS_DIV8: tick = &div_q;
            endcase
        end
    end
    assign count_en = run_q & tick;

    // =====================================================================
    // compare, capture and counter
    assign buf_en  = {buffer_pair_b_en_q, buffer_pair_a_en_q};
    assign buf_blk = {buf_en, 2'b00};
    assign pwm_en  = {pwm_q, 1'b0};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_chan
            assign cmp_match[gi] = count_en & ~io_q[gi*IO_FIELD_W + IO_CAP_BIT] & ~buf_blk[gi]
                                   & (main_count_q == gr_q[gi]);
            assign cap_ev[gi] = cap[gi] & ~buf_blk[gi];
            cct_chan u_chan (
                .i_clk          (I_REF_CLK),
                .i_rst          (I_SYS_RST),
                .i_pin_sync     (pins_s[gi]),
                .i_cap_mode     (io_q[gi*IO_FIELD_W + IO_CAP_BIT]),
                .i_cfg          (io_q[gi*IO_FIELD_W +: 2]),
                .i_match_own    (cmp_match[gi]),
                .i_match_period (cmp_match[0]),
                .i_pwm_en       (pwm_en[gi]),
                .i_preset       (wr_ctrl),
                .i_preset_val   (I_PWDATA[CTRL_LVL_LSB + gi]),
                .o_capture      (cap[gi]),
                .o_pin_out      (pin_out[gi])
            );
            if (gi < 2) begin : g_main
                always_ff @(posedge I_REF_CLK) begin
                    if (I_SYS_RST)                         gr_q[gi] <= '0;
                    else if (hit(gr_off(gi)))              gr_q[gi] <= I_PWDATA[CNT_W-1:0];
                    else if (cap_ev[gi])                   gr_q[gi] <= main_count_q;
                    else if (buf_en[gi] && cmp_match[gi])  gr_q[gi] <= gr_q[gi+2];
                end
            end else begin : g_buf
                always_ff @(posedge I_REF_CLK) begin
                    if (I_SYS_RST)                          gr_q[gi] <= '0;
                    else if (hit(gr_off(gi)))               gr_q[gi] <= I_PWDATA[CNT_W-1:0];
                    else if (buf_en[gi-2] && cap_ev[gi-2])  gr_q[gi] <= gr_q[gi-2];
                    else if (cap_ev[gi])                    gr_q[gi] <= main_count_q;
                end
            end
        end
    endgenerate

    assign clr_hit = clear_on_match_a_q & cmp_match[0];
    assign ovf     = count_en & (&main_count_q) & ~clr_hit;

    always_ff @(posedge I_REF_CLK) begin
        if (I_SYS_RST)     main_count_q <= '0;
        else if (wr_count) main_count_q <= I_PWDATA[CNT_W-1:0];
        else if (clr_hit)  main_count_q <= '0;
        else if (count_en) main_count_q <= main_count_q + 1'b1;
    end

    // =====================================================================
    // status and interrupt
    always_ff @(posedge I_REF_CLK) begin
        if (I_SYS_RST) status_q <= RST_FLAG;
        else           status_q <= (status_q & ~(wr_status ? I_PWDATA[4:0] : RST_FLAG))
                                   | {ovf, cmp_match | cap_ev};
    end

    always_ff @(posedge I_REF_CLK) begin
        if (I_SYS_RST) irq_q <= 1'b0;
        else           irq_q <= |(status_q & irq_en_q);
    end

    // =====================================================================
    // apb slave
    always_comb begin
        rdata_d = '0;
        err_d   = 1'b0;
        unique case (I_PADDR)
            OFF_MODE:    rdata_d = MODE_ONES | {24'h0, run_q, 1'b0, buffer_pair_b_en_q,
                                   buffer_pair_a_en_q, 1'b0, pwm_q};
            OFF_CTRL:    rdata_d = {24'h0, clear_on_match_a_q, cks_q, pin_out};
            OFF_IRQ_EN:  rdata_d = {27'h0, irq_en_q};
            OFF_STATUS:  rdata_d = {27'h0, status_q};
            OFF_IO_CTRL: rdata_d = {16'h0, io_q};
            OFF_COUNT:   rdata_d = 32'(main_count_q);
            gr_off(0):   rdata_d = 32'(gr_q[0]);
            gr_off(1):   rdata_d = 32'(gr_q[1]);
            gr_off(2):   rdata_d = 32'(gr_q[2]);
            gr_off(3):   rdata_d = 32'(gr_q[3]);
            default:     err_d   = 1'b1;
        endcase
    end

    always_ff @(posedge I_REF_CLK) begin
        if (I_SYS_RST) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= '0;
        end else begin
            pready_q  <= I_PSEL & ~I_PENABLE;
            pslverr_q <= I_PSEL & ~I_PENABLE & err_d;
            if (I_PSEL && !I_PENABLE && !I_PWRITE) prdata_q <= rdata_d;
        end
    end

    assign O_PRDATA          = prdata_q;
    assign O_PREADY          = pready_q;
    assign O_PSLVERR         = pslverr_q;
    assign O_IRQ             = irq_q;
    assign O_CHAN_A_PIN      = pin_out[0];
    assign O_CHAN_B_PIN      = pin_out[1];
    assign O_CHAN_C_PIN      = pin_out[2];
    assign O_CHAN_D_PIN      = pin_out[3];
    assign O_CHAN_A_PIN_OE_N = io_q[0*IO_FIELD_W + IO_CAP_BIT];
    assign O_CHAN_B_PIN_OE_N = io_q[1*IO_FIELD_W + IO_CAP_BIT];
    assign O_CHAN_C_PIN_OE_N = io_q[2*IO_FIELD_W + IO_CAP_BIT];
    assign O_CHAN_D_PIN_OE_N = io_q[3*IO_FIELD_W + IO_CAP_BIT];

    // =====================================================================
    // assertions
    a_count_halt: assert property (!run_q && !wr_count |=> main_count_q == $past(main_count_q))
        else $error("counter moved while halted");
    a_count_step: assert property (count_en && !wr_count && !clr_hit
        |=> main_count_q == CNT_W'($past(main_count_q) + 1'b1))
        else $error("counter did not step by one");
    a_clear_match: assert property (clr_hit && !wr_count |=> main_count_q == '0)
        else $error("counter not cleared on match a");
    a_free_run: assert property (!clear_on_match_a_q && cmp_match[0] && !wr_count && !(&main_count_q)
        |=> main_count_q != '0)
        else $error("counter cleared while free running");
    a_div_two: assert property ((tick && !cks_q[CKS_EXT_BIT] && cks_q[1:0] == CKS_DIV2 && !wr_ctrl)
        ##1 !wr_ctrl |-> !tick ##1 tick)
        else $error("divide by two tick spacing wrong");
    a_ovf_flag: assert property (ovf |=> status_q[ST_OVF_BIT] ##1 (status_q[ST_OVF_BIT] || $past(wr_status)))
        else $error("overflow flag not set");
    a_flag_sticky: assert property (status_q[ST_OVF_BIT] && !(wr_status && I_PWDATA[ST_OVF_BIT])
        |=> status_q[ST_OVF_BIT])
        else $error("overflow flag dropped without clear");
    a_irq_level: assert property ((status_q & irq_en_q) != '0 |=> O_IRQ)
        else $error("interrupt not raised");
    a_capture_load: assert property (cap_ev[1] && !hit(gr_off(1)) |=> gr_q[1] == $past(main_count_q))
        else $error("capture did not load counter");
    a_cap_flag: assert property (cap_ev[1] |=> status_q[1])
        else $error("capture flag not set");
    a_irq_drop: assert property ((status_q & irq_en_q) == '0 |=> !O_IRQ)
        else $error("interrupt raised without enabled flag");
    a_buf_transfer: assert property (buffer_pair_a_en_q && cmp_match[0] && !cap_ev[0] && !hit(gr_off(0))
        |=> gr_q[0] == $past(gr_q[2]))
        else $error("buffer value not transferred");
    a_toggle_out: assert property (cmp_match[0] && io_q[1:0] == ACT_TOGGLE && !wr_ctrl
        |=> O_CHAN_A_PIN != $past(O_CHAN_A_PIN))
        else $error("toggle output did not toggle");
    a_preset_out: assert property (wr_ctrl |=> pin_out == $past(I_PWDATA[3:0]))
        else $error("preset level not applied");
    a_pwm_rise: assert property (pwm_q[0] && cmp_match[1] && !wr_ctrl |=> O_CHAN_B_PIN)
        else $error("pwm output not set on duty match");
    a_oe_capture: assert property (io_q[IO_FIELD_W + IO_CAP_BIT] && $past(io_q[IO_FIELD_W + IO_CAP_BIT])
        && !$past(wr_ctrl) |-> O_CHAN_B_PIN_OE_N && $stable(O_CHAN_B_PIN))
        else $error("capture pin driven");
    a_apb_ready: assert property (I_PSEL && !I_PENABLE |=> O_PREADY)
        else $error("apb answer late");

    c_overflow: cover property (ovf ##1 O_IRQ);
    c_capture:  cover property (cap_ev[1]);
    c_buffer:   cover property (buffer_pair_a_en_q && cmp_match[0]);
    c_clear:    cover property (clr_hit);
    c_pwm:      cover property (pwm_q[0] && cmp_match[1]);
endmodule // cct_timer

//--- testbench/cct_pins.sv
// board side of the four channel pins
// assumes oe_n low while the timer drives a pin
`timescale 1ns/1ps
module cct_pins (
    input  wire logic [3:0] i_oe_n,
    input  wire logic [3:0] i_dev,
    input  wire logic [3:0] i_lvl,
    output logic      [3:0] o_pin
);
    // =========================================================
    // wire level: timer when enabled, board level otherwise
    assign o_pin = (i_oe_n & i_lvl) | (~i_oe_n & i_dev);
endmodule // cct_pins

//--- testbench/cct_timer_tb.sv
// self-checking bench for the capture/compare timer
// assumes apb slave on I_REF_CLK and the board model cct_pins
`timescale 1ns/1ps
module cct_timer_tb import cct_pkg::*;;
    logic        clk, rst, psel, pen, pwr, ext, pready, slverr, irq;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, r;
    logic [3:0]  lvl, pin, dout, oe_n;
    int          miscompares, total_checks, cyc, p, t0, i;
    logic [15:0] gm [4];
    logic [31:0] xmode;
    logic        se;
    int          dt;
    localparam logic [7:0] OFF_GR_B = OFF_GR_A + OFF_GR_STEP;
    cct_timer DUT (.I_REF_CLK(clk), .I_SYS_RST(rst), .I_PSEL(psel), .I_PENABLE(pen),
        .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
        .O_PREADY(pready), .O_PSLVERR(slverr), .I_EXT_EVENT_IN(ext),
        .I_CHAN_A_PIN(pin[0]), .I_CHAN_B_PIN(pin[1]), .I_CHAN_C_PIN(pin[2]), .I_CHAN_D_PIN(pin[3]),
        .O_CHAN_A_PIN(dout[0]), .O_CHAN_B_PIN(dout[1]), .O_CHAN_C_PIN(dout[2]),
        .O_CHAN_D_PIN(dout[3]), .O_CHAN_A_PIN_OE_N(oe_n[0]), .O_CHAN_B_PIN_OE_N(oe_n[1]),
        .O_CHAN_C_PIN_OE_N(oe_n[2]), .O_CHAN_D_PIN_OE_N(oe_n[3]), .O_IRQ(irq));
    cct_pins u_pins (.i_oe_n(oe_n), .i_dev(dout), .i_lvl(lvl), .o_pin(pin));
    always #10 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    // =========================================================
    // shared tasks
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        psel   <= 1'b1;
        pwr    <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            miscompares++;
            report_and_stop();
        end
        q = prdata;
        se = slverr;
        psel <= 1'b0;
        pen  <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        apb(1'b1, a, d, x);
    endtask
    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0, r);
    endtask
    task automatic restart(input logic [31:0] ctrl, input logic [15:0] cnt);
        wr(OFF_MODE, 32'h0);
        wr(OFF_COUNT, {16'h0, cnt});
        wr(OFF_CTRL, ctrl);
        wr(OFF_MODE, (32'h1 << MODE_RUN_BIT) | xmode);
    endtask
    task automatic wchg(input int k);
        logic v;
        int n;
        v = dout[k];
        n = 0;
        while (dout[k] === v && n < 2000) begin
            @(posedge clk);
            n++;
        end
        if (dout[k] === v) begin
            miscompares++;
            report_and_stop();
        end
    endtask
    // =========================================================
    // main sequence
    initial begin
        clk = 0;
        rst = 1;
        psel = 0;
        pen = 0;
        pwr = 0;
        paddr = 0;
        pwdata = 0;
        ext = 0;
        lvl = 0;
        xmode = 0;
        void'($urandom(32'hc788));
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(OFF_MODE); chk("mode", MODE_ONES, r);
        rd(OFF_STATUS); chk("status", 32'h0, r);
        chk("oe_n", 32'h0, oe_n);
        rd(8'hfc); chk("slverr", 32'h1, se);
        chk("bad_rd", 32'h0, r);
        for (i = 0; i < 4; i++) begin
            gm[i] = 16'($urandom);
            wr(8'(OFF_GR_A + 4 * i), {16'h0, gm[i]});
        end
        for (i = 0; i < 4; i++) begin
            rd(8'(OFF_GR_A + 4 * i)); chk("gr", gm[i], r);
        end
        p = 4 + $urandom % 20;
        wr(OFF_GR_A, p);
        wr(OFF_IO_CTRL, {30'h0, ACT_TOGGLE});
        wr(OFF_IRQ_EN, 32'h1);
        restart(32'h1 << CTRL_CLR_BIT, 16'h0);
        wchg(0);
        t0 = cyc;
        wchg(0);
        chk("period", p + 1, cyc - t0);
        wr(OFF_MODE, 32'h0);
        rd(OFF_STATUS); chk("flag_a", 32'h1, r[0]);
        chk("irq_on", 32'h1, irq);
        wr(OFF_IRQ_EN, 32'h0);
        repeat (2) @(posedge clk);
        chk("irq_mask", 32'h0, irq);
        wr(OFF_STATUS, 32'h1f);
        rd(OFF_STATUS); chk("clear", 32'h0, r[3:0]);
        wr(OFF_IRQ_EN, 32'h1 << ST_OVF_BIT);
        restart(32'h0, 16'hfffe);
        repeat (6) @(posedge clk);
        rd(OFF_STATUS); chk("ovf", 32'h1, r[ST_OVF_BIT]);
        chk("irq_ovf", 32'h1, irq);
        for (i = 0; i < 4; i++) begin
            restart(i << CTRL_CKS_LSB, 16'h0);
            repeat (64) @(posedge clk);
            rd(OFF_COUNT); chk("cks", 32'h1, r >= (64 >> i) && r <= (68 >> i) + 1);
        end
        restart(32'h4 << CTRL_CKS_LSB, 16'h0);
        repeat (5) begin
            ext <= 1'b1;
            repeat (3) @(posedge clk);
            ext <= 1'b0;
            repeat (3) @(posedge clk);
        end
        rd(OFF_COUNT); chk("ext", 32'h5, r);
        wr(OFF_IO_CTRL, 32'h1 << (IO_FIELD_W + IO_CAP_BIT));
        chk("oe_b", 32'h1, oe_n[1]);
        wr(OFF_STATUS, 32'h1f);
        restart(32'h0, 16'h0);
        p = 10 + $urandom % 50;
        repeat (p) @(posedge clk);
        lvl <= 4'h2;
        repeat (6) @(posedge clk);
        rd(OFF_STATUS); chk("cap_flag", 32'h1, r[1]);
        rd(OFF_GR_B); chk("cap_val", 32'h1, r >= p && r <= p + 8);
        wr(OFF_MODE, 32'h0);
        wr(OFF_IO_CTRL, 32'h0);
        p = $urandom % 16;
        wr(OFF_CTRL, p);
        chk("preset", p, dout);
        rd(OFF_CTRL); chk("preset_rd", p, r[3:0]);
        // =========================================================
        // buffer compare on pair a, one-output on channel a
        p = 8 + $urandom % 24;
        dt = 8 + $urandom % 24;
        wr(OFF_GR_A, p);
        wr(8'(OFF_GR_A + 2 * OFF_GR_STEP), dt);
        wr(OFF_IO_CTRL, 32'(ACT_ONE));
        wr(OFF_STATUS, 32'h1f);
        xmode = 32'h1 << MODE_BUF_A_BIT;
        restart(32'h1 << CTRL_CLR_BIT, 16'h0);
        repeat (100) @(posedge clk);
        rd(OFF_GR_A);
        chk("buf_a", dt, r);
        chk("act_one", 32'h1, dout[0]);
        rd(OFF_STATUS);
        chk("buf_c_flag", 32'h0, r[2]);
        // =========================================================
        // pwm on channel b, zero-output on channel d, period from register a
        wr(OFF_MODE, 32'h0);
        p = 8 + $urandom % 32;
        dt = 1 + $urandom % (p - 1);
        wr(OFF_GR_A, p);
        wr(OFF_GR_B, dt);
        wr(8'(OFF_GR_A + 3 * OFF_GR_STEP), dt);
        wr(OFF_IO_CTRL, 32'(ACT_ZERO) << (3 * IO_FIELD_W));
        xmode = 32'h1 << MODE_PWM_LSB;
        restart((32'h1 << CTRL_CLR_BIT) | 32'h8, 16'h0);
        wchg(1);
        t0 = cyc;
        wchg(1);
        chk("pwm_high", p - dt, cyc - t0);
        t0 = cyc;
        wchg(1);
        chk("pwm_low", dt + 1, cyc - t0);
        chk("act_zero", 32'h0, dout[3]);
        report_and_stop();
    end
endmodule // cct_timer_tb
